// ### logic/lss_lmfc_sync.sv
// LMFC to SYSREF phase alignment with register port and interrupt
`include "lss_defines.svh"

// Function
// - Window code n gives a tolerance of plus or minus n clocks.
// - Pulse mode waits the programmed LMFC periods before going active, or to monitor in monitor mode.
// - Rotate only after the programmed number of SYSREF pulses.
// - Under flag set when captured error fell below window.
// - Over flag set when captured error exceeded window.
// - Last error is nine bits; bit eight sits in upper bit zero.
// - Rising control bit 5 clears sticky rotated and tripped flags.
// - Rising control bit 4 clears last error and its flags.
// - Clocks untouched while error is inside window.
// - Mode codes: one shot, continuous, monitor, one shot then monitor.
// - On adjustment, copy the error measured at that pulse to last error, zero live error.
// - Rotated and tripped flags stay set until sticky clear.
module lss_lmfc_sync (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [`LSS_AW-1:0] reg_addr,
	input wire lss_pkg::lss_byte_t reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic sysref_in,
	output lss_pkg::lss_byte_t reg_rdata,
	output logic irq,
	output logic lmfc_edge
);
	import lss_pkg::*;

	// Register file
	logic [`LSS_WIN_W-1:0] window_q, window_d;
	lss_byte_t pulse_delay_periods_q, pulse_delay_periods_d;
	lss_byte_t pulses_per_rotate_q, pulses_per_rotate_d;
	lss_byte_t ctl_q, ctl_d;
	logic wr_ctl, clear_sticky_flags, clear_prev_error;
	logic align_arm_strobe, align_logic_on, mode_ok;
	logic [`LSS_MODE_HI:`LSS_MODE_LO] align_mode_select;

	// Sync machine
	lss_state_e state_q, state_d;
	lss_byte_t dcnt_q, dcnt_d, pcnt_q, pcnt_d;
	logic [`LSS_LMFC_W-1:0] lmfc_cnt_q, lmfc_cnt_d;
	lss_err_t live_phase_err_q, live_phase_err_d;
	lss_err_t prev_phase_err_q, prev_phase_err_d;
	logic prev_err_below_flag_q, prev_err_below_flag_d;
	logic prev_err_above_flag_q, prev_err_above_flag_d;
	logic tripped_flag_q, tripped_flag_d, rotated_q, rotated_d;
	logic wlim_q, wlim_d, lock_q, lock_d, sysref_q, lmfc_edge_q;

	// Events
	lss_err_t err_w;
	logic below_w, above_w, out_win, sysref_rise, listening;
	logic meas, reach, lmfc_wrap, rot_evt, trip_evt;

	// Interrupts and read port
	logic [`LSS_IRQ_N-1:0] irq_ev, irq_clr;
	logic [`LSS_IRQ_N-1:0] irq_st_q, irq_st_d, irq_en_q, irq_en_d;
	logic irq_q;
	lss_byte_t rdata_q, rdata_d;

	lss_window_chk u_window_chk (
		.lmfc_pos(lmfc_cnt_q),
		.phase_tolerance_window(window_q),
		.phase_err(err_w),
		.below(below_w),
		.above(above_w)
	);

	assign align_logic_on = ctl_q[`LSS_CTL_EN];
	assign align_mode_select = ctl_q[`LSS_MODE_HI:`LSS_MODE_LO];
	assign wr_ctl = reg_wr && (reg_addr == `LSS_A_ALIGNMENT_CONTROL);

	assign mode_ok = (align_mode_select == `LSS_MODE_ONE_SHOT) ||
		(align_mode_select == `LSS_MODE_CONTINUOUS) ||
		(align_mode_select == `LSS_MODE_MONITOR) ||
		(align_mode_select == `LSS_MODE_ONE_THEN_MON);

	assign align_arm_strobe = wr_ctl && reg_wdata[`LSS_CTL_ARM];
	assign clear_sticky_flags = wr_ctl &&
		reg_wdata[`LSS_CTL_CLR_STICKY] && !ctl_q[`LSS_CTL_CLR_STICKY];
	assign clear_prev_error = wr_ctl &&
		reg_wdata[`LSS_CTL_CLR_LAST] && !ctl_q[`LSS_CTL_CLR_LAST];

	always_comb begin : regs_next
		window_d = window_q;
		pulse_delay_periods_d = pulse_delay_periods_q;
		pulses_per_rotate_d = pulses_per_rotate_q;
		ctl_d = ctl_q;
		irq_en_d = irq_en_q;
		if (reg_wr) begin
			case (reg_addr)
				`LSS_A_WINDOW: window_d = reg_wdata[`LSS_WIN_W-1:0];
				`LSS_A_PULSE_DELAY_COUNT: pulse_delay_periods_d = reg_wdata;
				`LSS_A_PULSE_REFERENCE_COUNT: pulses_per_rotate_d = reg_wdata;
				`LSS_A_ALIGNMENT_CONTROL: begin
					ctl_d = reg_wdata;
					// Arm is a strobe and never stored
					ctl_d[`LSS_CTL_ARM] = 1'b0;
				end
				`LSS_A_IRQ_ENABLE: irq_en_d = reg_wdata[`LSS_IRQ_N-1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			window_q <= '0;
			pulse_delay_periods_q <= `LSS_RST8;
			pulses_per_rotate_q <= `LSS_RST8;
			ctl_q <= `LSS_RST8;
			irq_en_q <= '0;
		end else begin
			window_q <= window_d;
			pulse_delay_periods_q <= pulse_delay_periods_d;
			pulses_per_rotate_q <= pulses_per_rotate_d;
			ctl_q <= ctl_d;
			irq_en_q <= irq_en_d;
		end
	end

	assign sysref_rise = sysref_in && !sysref_q;
	assign listening = (state_q == LSS_ACTIVE) || (state_q == LSS_MONITOR);
	assign meas = sysref_rise && listening;
	assign out_win = below_w || above_w;
	assign lmfc_wrap = lmfc_cnt_q == `LSS_LMFC_LAST;
	assign reach = ({1'b0, pcnt_q} + `LSS_CNT_ONE) >=
		{1'b0, pulses_per_rotate_q};
	assign rot_evt = meas && (state_q == LSS_ACTIVE) && reach && out_win &&
		(align_mode_select != `LSS_MODE_MONITOR);
	assign trip_evt = sysref_rise && (state_q != LSS_IDLE);

	always_comb begin : sync_next
		state_d = state_q;
		dcnt_d = dcnt_q;
		pcnt_d = pcnt_q;
		if (!align_logic_on) begin
			state_d = LSS_IDLE;
			dcnt_d = `LSS_RST8;
			pcnt_d = `LSS_RST8;
		end else if (align_arm_strobe && mode_ok) begin
			state_d = LSS_DELAY;
			dcnt_d = `LSS_RST8;
			pcnt_d = `LSS_RST8;
		end else begin
			case (state_q)
				LSS_IDLE: ;
				LSS_DELAY: begin
					if (dcnt_q >= pulse_delay_periods_q) begin
						if (align_mode_select == `LSS_MODE_MONITOR) begin
							state_d = LSS_MONITOR;
						end else begin
							state_d = LSS_ACTIVE;
						end
					end else if (lmfc_wrap) begin
						dcnt_d = dcnt_q + 8'h01;
					end
				end
				LSS_ACTIVE: begin
					if (meas && reach) begin
						pcnt_d = `LSS_RST8;
						case (align_mode_select)
							`LSS_MODE_ONE_SHOT: state_d = LSS_IDLE;
							`LSS_MODE_ONE_THEN_MON: state_d = LSS_MONITOR;
							`LSS_MODE_MONITOR: state_d = LSS_MONITOR;
							`LSS_MODE_CONTINUOUS: state_d = LSS_ACTIVE;
							default: state_d = LSS_IDLE;
						endcase
					end else if (meas) begin
						pcnt_d = pcnt_q + 8'h01;
					end
				end
				LSS_MONITOR: ;
				default: state_d = LSS_IDLE;
			endcase
		end
	end

	always_comb begin : err_next
		lmfc_cnt_d = rot_evt ? `LSS_LMFC_ONE : lmfc_cnt_q + 1'b1;
		live_phase_err_d = live_phase_err_q;
		prev_phase_err_d = prev_phase_err_q;
		prev_err_below_flag_d = prev_err_below_flag_q;
		prev_err_above_flag_d = prev_err_above_flag_q;
		wlim_d = wlim_q;
		lock_d = lock_q;
		if (rot_evt) begin
			live_phase_err_d = '0;
			prev_phase_err_d = err_w;
			prev_err_below_flag_d = below_w;
			prev_err_above_flag_d = above_w;
		end else begin
			if (meas) begin
				live_phase_err_d = err_w;
			end
			if (clear_prev_error) begin
				prev_phase_err_d = '0;
				prev_err_below_flag_d = 1'b0;
				prev_err_above_flag_d = 1'b0;
			end
		end
		if (meas) begin
			wlim_d = out_win;
			lock_d = !out_win || rot_evt;
		end
		if (!align_logic_on) begin
			lock_d = 1'b0;
		end
		rotated_d = rot_evt || (rotated_q && !clear_sticky_flags);
		tripped_flag_d = trip_evt || (tripped_flag_q && !clear_sticky_flags);
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= LSS_IDLE;
			dcnt_q <= `LSS_RST8;
			pcnt_q <= `LSS_RST8;
			lmfc_cnt_q <= '0;
			sysref_q <= 1'b0;
			live_phase_err_q <= '0;
			prev_phase_err_q <= '0;
			prev_err_below_flag_q <= 1'b0;
			prev_err_above_flag_q <= 1'b0;
			tripped_flag_q <= 1'b0;
			rotated_q <= 1'b0;
			wlim_q <= 1'b0;
			lock_q <= 1'b0;
			lmfc_edge_q <= 1'b0;
		end else begin
			state_q <= state_d;
			dcnt_q <= dcnt_d;
			pcnt_q <= pcnt_d;
			lmfc_cnt_q <= lmfc_cnt_d;
			sysref_q <= sysref_in;
			live_phase_err_q <= live_phase_err_d;
			prev_phase_err_q <= prev_phase_err_d;
			prev_err_below_flag_q <= prev_err_below_flag_d;
			prev_err_above_flag_q <= prev_err_above_flag_d;
			tripped_flag_q <= tripped_flag_d;
			rotated_q <= rotated_d;
			wlim_q <= wlim_d;
			lock_q <= lock_d;
			lmfc_edge_q <= lmfc_cnt_d == '0;
		end
	end

	assign irq_ev[`LSS_IRQ_TRIP] = trip_evt;
	assign irq_ev[`LSS_IRQ_ROTATE] = rot_evt;
	assign irq_ev[`LSS_IRQ_WLIM] = meas && out_win;
	assign irq_clr = (reg_wr && (reg_addr == `LSS_A_IRQ_CLEAR)) ?
		reg_wdata[`LSS_IRQ_N-1:0] : '0;

	// Event set wins over a clear in the same cycle
	for (genvar g = 0; g < `LSS_IRQ_N; g++) begin : g_irq
		assign irq_st_d[g] = irq_ev[g] || (irq_st_q[g] && !irq_clr[g]);
	end

	always_comb begin : read_next
		rdata_d = `LSS_RST8;
		if (reg_rd) begin
			case (reg_addr)
				`LSS_A_WINDOW: rdata_d[`LSS_WIN_W-1:0] = window_q;
				`LSS_A_PULSE_DELAY_COUNT: rdata_d = pulse_delay_periods_q;
				`LSS_A_PULSE_REFERENCE_COUNT: rdata_d = pulses_per_rotate_q;
				`LSS_A_LAST_PHASE_ERROR_LOW: rdata_d = prev_phase_err_q[7:0];
				`LSS_A_LAST_PHASE_ERROR_HIGH: begin
					rdata_d[`LSS_LEH_UNDER] = prev_err_below_flag_q;
					rdata_d[`LSS_LEH_OVER] = prev_err_above_flag_q;
					rdata_d[`LSS_LEH_MSB] = prev_phase_err_q[`LSS_ERR_MSB];
				end
				`LSS_A_ALIGNMENT_CONTROL: rdata_d = ctl_q;
				`LSS_A_STATUS: begin
					rdata_d[`LSS_STS_BUSY] = state_q != LSS_IDLE;
					rdata_d[`LSS_STS_LOCK] = lock_q;
					rdata_d[`LSS_STS_ROTATE] = rotated_q;
					rdata_d[`LSS_STS_WLIM] = wlim_q;
					rdata_d[`LSS_STS_TRIP] = tripped_flag_q;
				end
				`LSS_A_LIVE_ERR_LOW: rdata_d = live_phase_err_q[7:0];
				`LSS_A_LIVE_ERR_HIGH:
					rdata_d[0] = live_phase_err_q[`LSS_ERR_MSB];
				`LSS_A_IRQ_STATUS: rdata_d[`LSS_IRQ_N-1:0] = irq_st_q;
				`LSS_A_IRQ_ENABLE: rdata_d[`LSS_IRQ_N-1:0] = irq_en_q;
				default: ;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_st_q <= '0;
			irq_q <= 1'b0;
			rdata_q <= `LSS_RST8;
		end else begin
			irq_st_q <= irq_st_d;
			irq_q <= |(irq_st_d & irq_en_d);
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign irq = irq_q;
	assign lmfc_edge = lmfc_edge_q;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	win_decode_a: assert property (
		(window_q == 3'h0) |-> ((err_w == '0) == !out_win))
		else $error("window zero decode wrong");
	dly_gate_a: assert property (
		(state_q == LSS_DELAY && dcnt_q < pulse_delay_periods_q) |=>
		(state_q == LSS_IDLE || state_q == LSS_DELAY))
		else $error("active before delay elapsed");
	ref_count_a: assert property (
		(meas && state_q == LSS_ACTIVE && !reach && align_logic_on &&
		!align_arm_strobe) |=> pcnt_q == $past(pcnt_q) + 8'h01)
		else $error("pulse count not advanced");
	under_flag_a: assert property (
		(rot_evt && below_w) |=> prev_err_below_flag_q && !prev_err_above_flag_q)
		else $error("under flag not set");
	over_flag_a: assert property (
		(rot_evt && above_w) |=> prev_err_above_flag_q && !prev_err_below_flag_q)
		else $error("over flag not set");
	err_split_a: assert property (
		(reg_rd && reg_addr == `LSS_A_LAST_PHASE_ERROR_HIGH) |=>
		reg_rdata[`LSS_LEH_MSB] == $past(prev_phase_err_q[`LSS_ERR_MSB]))
		else $error("last error msb misplaced");
	clr_sticky_a: assert property (
		(clear_sticky_flags && !trip_evt && !rot_evt) |=>
		!tripped_flag_q && !rotated_q)
		else $error("sticky flags not cleared");
	clr_last_a: assert property (
		(clear_prev_error && !rot_evt) |=> prev_phase_err_q == '0 &&
		!prev_err_below_flag_q && !prev_err_above_flag_q)
		else $error("last error not cleared");
	in_window_a: assert property (
		(meas && !out_win) |=> lmfc_cnt_q == $past(lmfc_cnt_q) + 1'b1)
		else $error("clock moved inside window");
	monitor_only_a: assert property (
		(state_q == LSS_MONITOR ||
		align_mode_select == `LSS_MODE_MONITOR) |=>
		lmfc_cnt_q == $past(lmfc_cnt_q) + 1'b1)
		else $error("monitor mode rotated");
	live_zero_a: assert property (
		rot_evt |=> live_phase_err_q == '0 &&
		prev_phase_err_q == $past(err_w) && lmfc_cnt_q == `LSS_LMFC_ONE)
		else $error("adjust capture wrong");
	sticky_hold_a: assert property (
		(rotated_q && tripped_flag_q && !clear_sticky_flags) |=>
		rotated_q && tripped_flag_q)
		else $error("sticky flag dropped");
	idle_off_a: assert property (
		!align_logic_on |=> state_q == LSS_IDLE)
		else $error("sync active while disabled");
	arm_start_a: assert property (
		(align_logic_on && align_arm_strobe && mode_ok &&
		wr_ctl && reg_wdata[`LSS_CTL_EN]) |=> state_q == LSS_DELAY)
		else $error("arm not taken");

	rotate_c: cover property (rot_evt);
	delay_done_c: cover property (state_q == LSS_DELAY ##1
		state_q == LSS_ACTIVE);
	in_window_c: cover property (meas && !out_win);
	irq_c: cover property (irq_q);
endmodule // lss_lmfc_sync

// ### logic/lss_defines.svh
// Register map, field positions and encodings of the LMFC sync block
`ifndef LSS_DEFINES_SVH
`define LSS_DEFINES_SVH

`define LSS_AW 8
`define LSS_A_WINDOW 8'h34
`define LSS_A_PULSE_DELAY_COUNT 8'h35
`define LSS_A_PULSE_REFERENCE_COUNT 8'h36
`define LSS_A_LAST_PHASE_ERROR_LOW 8'h38
`define LSS_A_LAST_PHASE_ERROR_HIGH 8'h39
`define LSS_A_ALIGNMENT_CONTROL 8'h3A
`define LSS_A_STATUS 8'h3B
`define LSS_A_LIVE_ERR_LOW 8'h3C
`define LSS_A_LIVE_ERR_HIGH 8'h3D
`define LSS_A_IRQ_STATUS 8'h40
`define LSS_A_IRQ_CLEAR 8'h41
`define LSS_A_IRQ_ENABLE 8'h42

`define LSS_RST8 8'h00
`define LSS_WIN_W 3
`define LSS_ERR_W 9
`define LSS_ERR_MSB 8
`define LSS_LMFC_W 5
`define LSS_LMFC_ONE 5'h01
`define LSS_LMFC_LAST 5'h1F
`define LSS_CNT_ONE 9'h001

`define LSS_CTL_EN 7
`define LSS_CTL_ARM 6
`define LSS_CTL_CLR_STICKY 5
`define LSS_CTL_CLR_LAST 4
`define LSS_MODE_HI 3
`define LSS_MODE_LO 0

`define LSS_MODE_ONE_SHOT 4'h1
`define LSS_MODE_CONTINUOUS 4'h2
`define LSS_MODE_MONITOR 4'h8
`define LSS_MODE_ONE_THEN_MON 4'h9

`define LSS_LEH_UNDER 7
`define LSS_LEH_OVER 6
`define LSS_LEH_MSB 0

`define LSS_STS_BUSY 7
`define LSS_STS_LOCK 3
`define LSS_STS_ROTATE 2
`define LSS_STS_WLIM 1
`define LSS_STS_TRIP 0

`define LSS_IRQ_N 3
`define LSS_IRQ_TRIP 0
`define LSS_IRQ_ROTATE 1
`define LSS_IRQ_WLIM 2

`endif

// ### logic/lss_pkg.sv
// Types shared by the LMFC sync block
package lss_pkg;
	typedef logic [7:0] lss_byte_t;
	typedef logic [8:0] lss_err_t;
	typedef enum logic [1:0] {
		LSS_IDLE,
		LSS_DELAY,
		LSS_ACTIVE,
		LSS_MONITOR
	} lss_state_e;
endpackage

// ### logic/lss_window_chk.sv
// Phase error from LMFC position and tolerance window compare
`include "lss_defines.svh"

module lss_window_chk (
	input wire logic [`LSS_LMFC_W-1:0] lmfc_pos,
	input wire logic [`LSS_WIN_W-1:0] phase_tolerance_window,
	output lss_pkg::lss_err_t phase_err,
	output logic below,
	output logic above
);
	import lss_pkg::*;

	logic signed [`LSS_ERR_W-1:0] err_s;
	logic signed [`LSS_ERR_W-1:0] win_s;

	// Upper half of the LMFC period counts as early (negative)
	assign err_s = {{(`LSS_ERR_W-`LSS_LMFC_W){lmfc_pos[`LSS_LMFC_W-1]}},
		lmfc_pos};
	assign win_s = {{(`LSS_ERR_W-`LSS_WIN_W){1'b0}},
		phase_tolerance_window};
	assign phase_err = err_s;
	assign below = err_s < -win_s;
	assign above = err_s > win_s;
endmodule // lss_window_chk

// ### testbench/lss_sysref_src.sv
// SYSREF pulse source model with three programmable gaps
module lss_sysref_src (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic fire,
	input wire logic [23:0] gaps,
	output logic sysref_in,
	output logic busy
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [23:0] g_q;
	logic [7:0] cnt_q;
	logic [1:0] wid_q;
	// Pulses are two clocks wide, so gaps below three are not supported
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			g_q <= 24'h000000;
			cnt_q <= 8'h00;
			wid_q <= 2'h0;
			sysref_in <= 1'b0;
			busy <= 1'b0;
		end else begin
			if (wid_q != 2'h0) wid_q <= wid_q - 2'h1;
			if (wid_q == 2'h1) sysref_in <= 1'b0;
			if (fire) begin
				g_q <= gaps >> 8;
				cnt_q <= gaps[7:0];
				busy <= 1'b1;
			end else if (busy) begin
				if (cnt_q > 8'h01) cnt_q <= cnt_q - 8'h01;
				else begin
					sysref_in <= 1'b1;
					wid_q <= 2'h2;
					cnt_q <= g_q[7:0];
					g_q <= g_q >> 8;
					busy <= (g_q[7:0] != 8'h00);
				end
			end
		end
	end
endmodule // lss_sysref_src

// ### testbench/lss_lmfc_sync_tb.sv
// Self-checking bench for the LMFC sync block
module lss_lmfc_sync_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import lss_pkg::*;
	logic ref_clk, rst_b, reg_wr, reg_rd, sysref_in, irq, lmfc_edge;
	logic fire, src_busy, sr_prev;
	logic [7:0] reg_addr;
	lss_byte_t reg_wdata, reg_rdata, rd_v;
	logic [23:0] gaps;
	int failures, num_checks, cyc, ref_c, win, g1, g2;
	int rises[$];
	logic exp_rot, exp_trip, exp_under, exp_over;
	lss_err_t exp_err, exp_live;
	lss_byte_t rst_regs [5] = '{8'h35, 8'h36, 8'h38, 8'h39, 8'h3A};
	lss_byte_t modes [3] = '{8'h01, 8'h09, 8'h08};

	lss_lmfc_sync uut (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.sysref_in(sysref_in), .reg_rdata(reg_rdata), .irq(irq),
		.lmfc_edge(lmfc_edge));
	lss_sysref_src src (.ref_clk(ref_clk), .rst_b(rst_b), .fire(fire),
		.gaps(gaps), .sysref_in(sysref_in), .busy(src_busy));

	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	// Rise edges as the block samples them, plus the hang guard
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		sr_prev <= sysref_in;
		if (sysref_in && !sr_prev) rises.push_back(cyc);
		if (cyc > 20000) begin
			failures++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic check(string what, logic [8:0] seen, logic [8:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// A gap edge after each strobe keeps every strobe one cycle long
	task automatic wr(logic [7:0] a, lss_byte_t d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic rd(logic [7:0] a);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(posedge ref_clk);
		rd_v = reg_rdata;
	endtask

	task automatic chk_reg(string what, logic [7:0] a, lss_byte_t m,
		lss_byte_t exp);
		rd(a);
		check(what, {1'b0, rd_v & m}, {1'b0, exp & m});
	endtask

	task automatic chk_irq(string what, logic exp);
		@(posedge ref_clk);
		check(what, {8'h00, irq}, {8'h00, exp});
	endtask

	// Reference model: error is LMFC count at the rise, signed mod 32
	task automatic meas(int c);
		int d;
		int e;
		d = ((c - ref_c) % 32 + 32) % 32;
		e = (d < 16) ? d : d - 32;
		exp_live = e[8:0];
		if (e > win || e < -win) begin
			exp_err = e[8:0];
			exp_under = (e < -win);
			exp_over = (e > win);
			ref_c = c;
			exp_rot = 1'b1;
			exp_live = 9'h000;
		end
	endtask

	task automatic clr(lss_byte_t ctl);
		wr(8'h3A, ctl);
		wr(8'h3A, ctl | 8'h30);
		wr(8'h3A, ctl);
		wr(8'h41, 8'h07);
		exp_rot = 1'b0;
		exp_trip = 1'b0;
		exp_err = 9'h000;
		exp_under = 1'b0;
		exp_over = 1'b0;
	endtask

	task automatic chk_all();
		chk_reg("last_low", 8'h38, 8'hFF, exp_err[7:0]);
		chk_reg("last_high", 8'h39, 8'hFF,
			{exp_under, exp_over, 5'h00, exp_err[8]});
		chk_reg("status", 8'h3B, 8'h05,
			{5'h00, exp_rot, 1'b0, exp_trip});
		chk_edge();
	endtask

	// Local LMFC phase against the model, only between SYSREF trains
	task automatic chk_edge();
		repeat (32) begin
			@(posedge ref_clk);
			check("lmfc_edge", {8'h00, lmfc_edge},
				{8'h00, ((cyc - ref_c) % 32 + 32) % 32 == 0});
		end
	endtask

	task automatic train(logic [23:0] g);
		rises.delete();
		fire <= 1'b1;
		gaps <= g;
		@(posedge ref_clk);
		fire <= 1'b0;
		@(posedge ref_clk);
		while (src_busy) @(posedge ref_clk);
		repeat (4) @(posedge ref_clk);
	endtask

	initial begin
		rst_b = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		fire = 1'b0;
		gaps = 24'h000000;
		sr_prev = 1'b0;
		// LMFC count is zero at the first edge after reset, bench cycle 8
		ref_c = 8;
		cyc = 0;
		failures = 0;
		num_checks = 0;
		repeat (8) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
		foreach (rst_regs[i]) chk_reg("reset", rst_regs[i], 8'hFF, 8'h00);
		wr(8'h35, 8'hA5);
		chk_reg("delay_rw", 8'h35, 8'hFF, 8'hA5);
		wr(8'h38, 8'h5A);
		chk_reg("ro_low", 8'h38, 8'hFF, 8'h00);
		chk_reg("unmapped", 8'h37, 8'hFF, 8'h00);
		$display("test registers done");

		wr(8'h35, 8'h00);
		wr(8'h36, 8'h00);
		for (int w = 0; w < 8; w++) begin
			for (int s = 0; s < 2; s++) begin
				win = w;
				g1 = s ? 31 - w : 33 + w;
				g2 = s ? 32 - w : 32 + w;
				wr(8'h34, w[7:0]); // window code
				clr(8'h82);
				chk_all(); // cleared
				wr(8'h3A, 8'hC2); // arm
				chk_reg("arm_reads0", 8'h3A, 8'hFF, 8'h82); // mode
				train({g2[7:0], g1[7:0], 8'h08});
				foreach (rises[i]) meas(rises[i]);
				exp_trip = 1'b1;
				chk_all(); // capture
				chk_reg("live_low", 8'h3C, 8'hFF, exp_live[7:0]);
				chk_reg("live_high", 8'h3D, 8'hFF,
					{7'h00, exp_live[8]});
			end
		end
		$display("test window sweep done");

		chk_reg("irq_status", 8'h40, 8'h07, 8'h07);
		chk_irq("irq_masked", 1'b0);
		wr(8'h42, 8'h02);
		chk_irq("irq_on", 1'b1);
		wr(8'h41, 8'h02);
		chk_irq("irq_cleared", 1'b0);
		chk_reg("irq_left", 8'h40, 8'h07, 8'h05);
		wr(8'h42, 8'h07);
		chk_irq("irq_other", 1'b1);
		wr(8'h41, 8'h07);
		chk_irq("irq_none", 1'b0);
		$display("test interrupt done");

		clr(8'h02);
		wr(8'h3A, 8'h42); // arm while off
		train(24'h202008);
		chk_all(); // stays idle
		$display("test disabled done");

		wr(8'h35, 8'h02);
		wr(8'h34, 8'h02);
		win = 2;
		foreach (modes[i]) begin
			clr(8'h80 | modes[i]);
			wr(8'h3A, 8'hC0 | modes[i]); // arm
			train(24'h287804);
			if (modes[i] != 8'h08) meas(rises[1]);
			exp_trip = 1'b1;
			chk_all(); // delay and mode
		end
		$display("test delay and modes done");

		wr(8'h35, 8'h00);
		wr(8'h36, 8'h03);
		clr(8'h82);
		wr(8'h3A, 8'hC2);
		train(24'h282808);
		meas(rises[2]);
		exp_trip = 1'b1;
		chk_all(); // third pulse counts
		$display("test pulse count done");
		wrap_up();
	end
endmodule // lss_lmfc_sync_tb
